// File: pic_channel.sv
// Purpose: host end of the primary disk channel pins
// Assumes: drive inputs asynchronous, sampled at 125 MHz
// Notes: ultra dma burst edges detected on the synchronised ready pin
`timescale 1ns/10ps
`default_nettype none
`include "pic_cfg.svh"
module pic_channel
	import pic_pkg::*;
#(
	parameter int STROBE_CYC = `PIC_STROBE_CYC,
	parameter int SETUP_CYC = `PIC_SETUP_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic suspend,
	input wire logic twoDeviceMode,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [15:0] reqAddr,
	input wire logic [15:0] reqWdata,
	input wire logic dmaCycle,
	input wire logic udmaStart,
	input wire logic udmaWrite,
	input wire logic udmaPause,
	input wire logic udmaStop,
	input wire logic [15:0] disk_data_bus_i,
	input wire logic disk_dma_request,
	input wire logic disk_ready_in,
	output logic [15:0] disk_data_bus_o,
	output logic disk_data_bus_oe,
	output logic [2:0] disk_reg_select,
	output logic disk_reg_select_oe,
	output logic cmd_block_select_n,
	output logic ctl_block_select_n,
	output logic disk_read_strobe_n,
	output logic disk_write_strobe_n,
	output logic disk_dma_ack_n,
	output logic reqDone,
	output logic isaForward,
	output logic [15:0] rdData,
	output logic rdValid,
	output logic dmaReqSync,
	output logic connectorSel
);
	typedef struct packed {
		pic_state_t st;
		logic [7:0] cnt;
		logic [1:0] reqS;
		logic [1:0] rdyS;
		logic rdyLast;
		logic wr;
		logic [15:0] dat0;
		logic [15:0] dat1;
		logic [15:0] dout;
		logic oe;
		logic [2:0] da;
		logic aoe;
		logic cs1;
		logic cs3;
		logic ior;
		logic iow;
		logic ack;
		logic done;
		logic fwd;
		logic [15:0] rd;
		logic rdv;
		logic con;
	} pic_reg_t;

	pic_reg_t q, d;

	function automatic logic isCmd(input logic [15:0] a);
		return a >= `PIC_CMD_BASE && a <= `PIC_CMD_LAST;
	endfunction

	function automatic logic isCtlBlk(input logic [15:0] a);
		return a[15:3] == 13'(`PIC_CTL_BASE >> 3);
	endfunction

	logic rdyNow;
	logic rdyEdge;
	assign rdyNow = q.rdyS[1];
	assign rdyEdge = rdyNow ^ q.rdyLast;

	always_comb begin
		d = q;
		d.reqS = {q.reqS[0], disk_dma_request};
		d.rdyS = {q.rdyS[0], disk_ready_in};
		d.rdyLast = rdyNow;
		// data rides the same two flops as ready; a pio strobe must outlast this lag
		d.dat0 = disk_data_bus_i;
		d.dat1 = q.dat0;
		d.done = 1'b0;
		d.fwd = 1'b0;
		d.rdv = 1'b0;
		d.con = twoDeviceMode;
		if (suspend) begin
			d.st = PIC_IDLE;
			d.cs1 = 1'b1;
			d.cs3 = 1'b1;
			d.ior = 1'b1;
			d.iow = 1'b1;
			d.ack = 1'b1;
			d.oe = 1'b0;
		end else begin
			unique case (q.st)
				PIC_IDLE: begin
					d.cs1 = 1'b1;
					d.cs3 = 1'b1;
					d.ior = 1'b1;
					d.iow = 1'b1;
					d.ack = 1'b1;
					if (udmaStart) begin
						d.st = PIC_UDMA;
						d.ack = 1'b0;
						d.wr = udmaWrite;
						d.oe = udmaWrite;
						d.dout = reqWdata;
						d.ior = udmaWrite ? 1'b1 : udmaPause;
					end else if (reqValid) begin
						if (!dmaCycle && isCtlBlk(reqAddr) && reqAddr != `PIC_CTL_ADDR) begin
							d.fwd = 1'b1;
							d.done = 1'b1;
						end else if (dmaCycle || isCmd(reqAddr) || reqAddr == `PIC_CTL_ADDR) begin
							d.st = PIC_SETUP;
							d.cnt = 8'(SETUP_CYC);
							d.wr = reqWrite;
							d.da = reqAddr[2:0];
							d.aoe = 1'b1;
							d.cs1 = !(!dmaCycle && isCmd(reqAddr));
							d.cs3 = !(!dmaCycle && reqAddr == `PIC_CTL_ADDR);
							d.ack = !dmaCycle;
							d.oe = reqWrite;
							d.dout = reqWdata;
						end else begin
							d.done = 1'b1;
						end
					end
				end
				PIC_SETUP: begin
					if (q.cnt <= 8'h01) begin
						d.st = PIC_STROBE;
						d.cnt = 8'(STROBE_CYC);
						d.ior = q.wr;
						d.iow = !q.wr;
					end else begin
						d.cnt = q.cnt - 8'h01;
					end
				end
				PIC_STROBE: begin
					if (q.cnt <= 8'h01) begin
						d.st = PIC_HOLD;
						d.ior = 1'b1;
						d.iow = 1'b1;
						if (!q.wr) begin
							d.rd = q.dat1;
							d.rdv = 1'b1;
						end
					end else begin
						d.cnt = q.cnt - 8'h01;
					end
				end
				PIC_HOLD: begin
					d.st = PIC_IDLE;
					d.ior = 1'b1;
					d.iow = 1'b1;
					d.cs1 = 1'b1;
					d.cs3 = 1'b1;
					d.ack = 1'b1;
					d.oe = 1'b0;
					d.done = 1'b1;
				end
				PIC_UDMA: begin
					if (q.wr) begin
						// data strobe toggles only while drive signals ready (low)
						if (!rdyNow && !udmaPause) begin
							d.ior = !q.ior;
							d.dout = reqWdata;
						end
					end else begin
						d.ior = udmaPause;
						if (rdyEdge) begin
							// word and strobe passed the same two flops, so they stay paired
							d.rd = q.dat1;
							d.rdv = 1'b1;
						end
					end
					if (udmaStop) begin
						d.iow = 1'b0;
						d.st = PIC_HOLD;
						d.ior = 1'b1;
					end
				end
				default: d.st = PIC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= PIC_IDLE;
			q.cs1 <= 1'b1;
			q.cs3 <= 1'b1;
			q.ior <= 1'b1;
			q.iow <= 1'b1;
			q.ack <= 1'b1;
			q.oe <= 1'b0;
			q.aoe <= 1'b0;
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign disk_data_bus_o = q.dout;
	assign disk_data_bus_oe = q.oe;
	assign disk_reg_select = q.da;
	assign disk_reg_select_oe = q.aoe;
	assign cmd_block_select_n = q.cs1;
	assign ctl_block_select_n = q.cs3;
	assign disk_read_strobe_n = q.ior;
	assign disk_write_strobe_n = q.iow;
	assign disk_dma_ack_n = q.ack;
	assign reqDone = q.done;
	assign isaForward = q.fwd;
	assign rdData = q.rd;
	assign rdValid = q.rdv;
	assign dmaReqSync = q.reqS[1];
	assign connectorSel = q.con;

	sequence s_stop_pulse;
		!disk_write_strobe_n ##1 disk_write_strobe_n;
	endsequence

	a_reset_pins: assert property (@(posedge clk) !rst_n |=> cmd_block_select_n
		&& ctl_block_select_n && disk_read_strobe_n && disk_write_strobe_n && disk_dma_ack_n)
		else $error("pins low after reset");
	a_reset_float: assert property (@(posedge clk) !rst_n |=> !disk_data_bus_oe
		&& !disk_reg_select_oe) else $error("bus driven after reset");
	a_cmd_select: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && !suspend && q.st == PIC_IDLE && reqValid && !udmaStart && !dmaCycle && isCmd(reqAddr)
		|=> !cmd_block_select_n && ctl_block_select_n) else $error("command select wrong");
	a_ctl_select: assert property (@(posedge clk) disable iff (!rst_n)
		!ctl_block_select_n |-> q.st != PIC_IDLE && disk_reg_select == 3'h6)
		else $error("control select stray");
	a_isa_fwd: assert property (@(posedge clk) disable iff (!rst_n)
		isaForward |-> ctl_block_select_n && cmd_block_select_n) else $error("forward with select");
	a_ack_no_cs: assert property (@(posedge clk) disable iff (!rst_n)
		!disk_dma_ack_n |-> cmd_block_select_n && ctl_block_select_n) else $error("ack with select");
	a_pio_capture: assert property (@(posedge clk) disable iff (!rst_n)
		rdValid && q.st == PIC_HOLD |-> $rose(disk_read_strobe_n)) else $error("read data not at edge");
	a_stop_ends: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && !suspend && q.st == PIC_UDMA && udmaStop |=> s_stop_pulse) else $error("stop not issued");
	a_suspend_hold: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && suspend |=> disk_read_strobe_n && disk_write_strobe_n && disk_dma_ack_n)
		else $error("strobe active in suspend");
	a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!clkEn |=> $stable(q)) else $error("state moved while frozen");
endmodule
`default_nettype wire

// File: pic_cfg.svh
// Purpose: constants for the primary disk channel pin engine
// Assumes: 125 MHz core clock
// Notes: addresses are 16-bit I/O port numbers
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_CMD_BASE 16'h01F0
`define PIC_CMD_LAST 16'h01F7
`define PIC_CTL_ADDR 16'h03F6
`define PIC_CTL_BASE 16'h03F0
`define PIC_STROBE_NS 120
`define PIC_SETUP_NS 40
`define PIC_CLK_NS 8
`define PIC_STROBE_CYC ((`PIC_STROBE_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_SETUP_CYC ((`PIC_SETUP_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`endif

// File: pic_pkg.sv
// Purpose: types for the primary disk channel pin engine
// Assumes: nothing beyond the header
// Notes: state codes written out
package pic_pkg;
	typedef enum logic [2:0] {
		PIC_IDLE = 3'h0,
		PIC_SETUP = 3'h1,
		PIC_STROBE = 3'h2,
		PIC_HOLD = 3'h3,
		PIC_UDMA = 3'h4
	} pic_state_t;
endpackage

// File: pic_drive_model.sv
// Purpose: behavioural disk drive on the primary connector
// Assumes: host strobes are active low
// Notes: a released bus shows the inverse word, not the last value
`timescale 1ns/10ps
`default_nettype none
module pic_drive_model (
	input wire logic readN,
	input wire logic writeN,
	input wire logic dmaAckN,
	input wire logic hostOe,
	input wire logic [15:0] hostData,
	input wire logic [15:0] readWord,
	output logic [15:0] diskData,
	output logic [15:0] lastWrite,
	output logic [15:0] udmaWord,
	output logic [15:0] udmaEdges
);
	logic [15:0] edges = 16'h0000;
	// drive latches host data at the end of the write strobe; undriven bus reads as zero
	always @(posedge writeN) lastWrite = hostOe ? hostData : 16'h0000;
	// ultra write: every strobe edge under acknowledge carries a word
	always @(readN) begin
		if (!dmaAckN && hostOe) begin
			udmaWord = hostData;
			edges = edges + 16'h0001;
		end
	end
	assign udmaEdges = edges;
	// drive the read word while the read strobe is low, its inverse otherwise
	assign diskData = !readN ? readWord : ~readWord;
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench for the primary disk channel pins
// Assumes: short setup and strobe counts keep the run brief
// Notes: ready pin and request are driven here in the drive's place
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pic_pkg::*;
	logic clk = 0, rst_n = 0, clkEn = 1, suspend = 0, twoDeviceMode = 0, reqValid = 0;
	logic reqWrite = 0, dmaCycle = 0, udmaStart = 0, udmaWrite = 0, udmaPause = 0, udmaStop = 0;
	logic disk_dma_request = 0, disk_ready_in = 0, disk_data_bus_oe, disk_reg_select_oe;
	logic cmd_block_select_n, ctl_block_select_n, disk_read_strobe_n, disk_write_strobe_n;
	logic disk_dma_ack_n, reqDone, isaForward, rdValid, dmaReqSync, connectorSel;
	logic sCmd, sCtl, sAck, fwd, wStop;
	logic [2:0] disk_reg_select, sel;
	logic [15:0] reqAddr = 0, reqWdata = 0, disk_data_bus_i, disk_data_bus_o, rdData, rd, lastW;
	logic [15:0] rw = 16'hA5C3;
	logic [15:0] udmaWord, udmaEdges;
	int n_mismatch = 0, n_checks = 0, cnt;
	always #4 clk = ~clk;
	pic_channel #(.STROBE_CYC(4), .SETUP_CYC(1)) dut (.clk, .rst_n, .clkEn, .suspend,
		.twoDeviceMode, .reqValid, .reqWrite, .reqAddr, .reqWdata, .dmaCycle, .udmaStart,
		.udmaWrite, .udmaPause, .udmaStop, .disk_data_bus_i, .disk_dma_request, .disk_ready_in,
		.disk_data_bus_o, .disk_data_bus_oe, .disk_reg_select, .disk_reg_select_oe,
		.cmd_block_select_n, .ctl_block_select_n, .disk_read_strobe_n, .disk_write_strobe_n,
		.disk_dma_ack_n, .reqDone, .isaForward, .rdData, .rdValid, .dmaReqSync, .connectorSel);
	pic_drive_model drive (.readN(disk_read_strobe_n), .writeN(disk_write_strobe_n),
		.dmaAckN(disk_dma_ack_n), .hostOe(disk_data_bus_oe), .hostData(disk_data_bus_o),
		.readWord(rw), .diskData(disk_data_bus_i), .lastWrite(lastW), .udmaWord, .udmaEdges);
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pins_high(input string n);
		chk(n, 16'h001F, {11'h000, cmd_block_select_n, ctl_block_select_n, disk_read_strobe_n,
			disk_write_strobe_n, disk_dma_ack_n});
	endtask
	// one pio or dma cycle, watching the pins until done
	task automatic cyc(input logic [15:0] a, input logic w, input logic d);
		int i;
		logic done;
		{sCmd, sCtl, sAck, fwd, done} = 0;
		reqAddr = a;
		reqWrite = w;
		reqWdata = ~a;
		dmaCycle = d;
		reqValid = 1;
		for (i = 0; i < 60 && !done; i++) begin
			step;
			reqValid = 0;
			sCmd |= !cmd_block_select_n;
			sCtl |= !ctl_block_select_n;
			sAck |= !disk_dma_ack_n;
			fwd |= isaForward;
			if (!disk_read_strobe_n || !disk_write_strobe_n) sel = disk_reg_select;
			if (rdValid === 1'b1) rd = rdData;
			done = reqDone === 1'b1;
		end
		chk("done", 16'h0001, {15'h0, done});
		step;
	endtask
	task automatic t_reset;
		pins_high("rst pins");
		chk("rst oe", 16'h0000, {14'h0, disk_data_bus_oe, disk_reg_select_oe});
	endtask
	task automatic t_cmd_reads;
		for (int a = 16'h01F0; a <= 16'h01F7; a++) begin
			rd = 0;
			cyc(a[15:0], 0, 0);
			chk("cmd sel", 16'h0002, {14'h0, sCmd, sCtl});
			chk("addr", {13'h0, a[2:0]}, {13'h0, sel});
			chk("rd data", rw, rd);
		end
	endtask
	task automatic t_ctl_write;
		cyc(16'h03F6, 1, 0);
		chk("ctl sel", 16'h0001, {14'h0, sCmd, sCtl});
		chk("wr data", 16'hFC09, lastW);
		cyc(16'h03F1, 0, 0);
		chk("fwd", 16'h0001, {14'h0, sCtl, fwd});
		cyc(16'h01F8, 0, 0);
		chk("ignored", 16'h0000, {13'h0, sCmd, sCtl, fwd});
	endtask
	task automatic t_dma;
		rd = 0;
		cyc(16'h0000, 0, 1);
		chk("dma ack", 16'h0004, {13'h0, sAck, sCmd, sCtl});
		chk("dma data", rw, rd);
		disk_dma_request = 1;
		twoDeviceMode = 1;
		step;
		chk("req early", 16'h0001, {14'h0, dmaReqSync, connectorSel});
		repeat (3) step;
		chk("req sync", 16'h0003, {14'h0, dmaReqSync, connectorSel});
	endtask
	task automatic t_udma;
		cnt = 0;
		wStop = 0;
		udmaStart = 1;
		step;
		udmaStart = 0;
		for (int i = 0; i < 60; i++) begin
			step;
			// ready toggles at the 80 ns link rate, only inside the burst
			if (i % 10 == 0 && i < 40) disk_ready_in = ~disk_ready_in;
			if (rdValid === 1'b1) cnt++;
		end
		chk("strobes", 16'h0004, cnt[15:0]);
		chk("udma data", rw, rdData);
		chk("ack", 16'h0000, {15'h0, disk_dma_ack_n});
		udmaPause = 1;
		repeat (3) step;
		chk("paused", 16'h0001, {15'h0, disk_read_strobe_n});
		udmaPause = 0;
		udmaStop = 1;
		for (int i = 0; i < 30 && reqDone !== 1'b1; i++) begin
			step;
			wStop |= !disk_write_strobe_n;
		end
		udmaStop = 0;
		chk("stop", 16'h0003, {14'h0, wStop, reqDone});
		step;
	endtask
	task automatic t_udma_write;
		logic [15:0] e;
		udmaWrite = 1;
		reqWdata = 16'h3C5A;
		udmaStart = 1;
		step;
		udmaStart = 0;
		repeat (6) step;
		chk("wr oe", 16'h0001, {15'h0, disk_data_bus_oe});
		disk_ready_in = 1;
		repeat (4) step;
		e = udmaEdges;
		repeat (4) step;
		chk("paused edges", e, udmaEdges);
		chk("edges seen", 16'h0001, {15'h0, e > 16'h0004});
		chk("udma word", 16'h3C5A, udmaWord);
		udmaStop = 1;
		step;
		step;
		udmaStop = 0;
		chk("wr stop", 16'h0001, {15'h0, reqDone});
		udmaWrite = 0;
		step;
	endtask
	task automatic t_freeze;
		dmaCycle = 0;
		reqWrite = 0;
		reqAddr = 16'h01F1;
		reqValid = 1;
		step;
		reqValid = 0;
		step;
		clkEn = 0;
		repeat (4) step;
		chk("frozen", 16'h0000, {14'h0, cmd_block_select_n, disk_read_strobe_n});
		clkEn = 1;
		for (int i = 0; i < 20 && reqDone !== 1'b1; i++) step;
		chk("thawed", 16'h0001, {15'h0, reqDone === 1'b1});
		step;
	endtask
	task automatic t_midreset;
		reqWrite = 1;
		reqAddr = 16'h01F0;
		reqValid = 1;
		step;
		reqValid = 0;
		step;
		rst_n = 0;
		step;
		pins_high("mid rst pins");
		chk("mid rst oe", 16'h0000, {14'h0, disk_data_bus_oe, disk_reg_select_oe});
		step;
		rst_n = 1;
		step;
		pins_high("mid idle pins");
	endtask
	task automatic t_suspend;
		reqAddr = 16'h01F2;
		reqWrite = 1;
		reqValid = 1;
		step;
		step;
		suspend = 1;
		reqValid = 0;
		repeat (2) step;
		pins_high("susp pins");
		chk("susp oe", 16'h0000, {15'h0, disk_data_bus_oe});
		suspend = 0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) step;
		t_reset();
		rst_n = 1;
		t_cmd_reads();
		t_ctl_write();
		t_dma();
		t_udma();
		t_udma_write();
		t_freeze();
		t_midreset();
		t_suspend();
		stop_test();
	end
	// hang guard, well past the few hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
